/* File: logic/adc_diag_mod_chop_regs.sv */
// Diagnostic routing, delayed modulator clock and chop rate register bank on APB.
// Assumes an APB master on ref_clk; the channel-mode and precharge buffer settings are inputs.
`timescale 1ns/1ns
`include "diag_chop_defines.svh"

module adc_diag_mod_chop_regs #(
    parameter int NUM_CH = 8
) (
    input wire logic ref_clk, // Clock, 25 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic clkEn, // Blocks register writes and read data capture while low; srst still resets
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [NUM_CH-1:0] chanModeB, // Channel is in mode group B when high
    input wire logic [NUM_CH-1:0] prechargeBufOn, // Input precharge buffer is on
    output diag_chop_pkg::diag_level_t chanDiagLevel [NUM_CH], // Level driven into each channel
    output logic [NUM_CH-1:0] delayedModclkUse, // Channel runs on the delayed modulator clock
    output diag_chop_pkg::chop_rate_t group_a_chop_rate, // Group A chop rate
    output diag_chop_pkg::chop_rate_t group_b_chop_rate // Group B chop rate
);
    import diag_chop_pkg::*;

    initial begin
        if (NUM_CH != 8) begin
            $error("adc_diag_mod_chop_regs serves exactly eight channels");
        end
    end

    logic [7:0] diagRx_q;
    logic [7:0] diagSel_q;
    logic [7:0] modDelay_q;
    logic [7:0] chop_q;
    logic [9:0] wordIdx;
    logic hitRx;
    logic hitSel;
    logic hitDel;
    logic hitChop;
    logic mapped;
    logic wrStrobe;
    logic [2:0] group_a_diag_voltage;
    logic [2:0] group_b_diag_voltage;
    logic [1:0] delayed_modclk_select;

    assign wordIdx = paddr[11:2];
    assign hitRx = (wordIdx == {2'h0, `DIAG_RX_IDX});
    assign hitSel = (wordIdx == {2'h0, `DIAG_SEL_IDX});
    assign hitDel = (wordIdx == {2'h0, `MOD_DELAY_IDX});
    assign hitChop = (wordIdx == {2'h0, `CHOP_IDX});
    assign mapped = hitRx | hitSel | hitDel | hitChop;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wrStrobe = clkEn & psel & penable & pwrite & mapped;

    // Receive enables, one bit per channel
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            diagRx_q <= `DIAG_RX_RST;
        end else if (wrStrobe && hitRx) begin
            diagRx_q <= pwdata[7:0];
        end
    end

    // Group A and B level selections, stored as written
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            diagSel_q <= `DIAG_SEL_RST;
        end else if (wrStrobe && hitSel) begin
            diagSel_q <= pwdata[7:0];
        end
    end

    // Delayed clock select and the reserved pair
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            modDelay_q <= `MOD_DELAY_RST;
        end else if (wrStrobe && hitDel) begin
            modDelay_q <= pwdata[7:0];
        end
    end

    // Chop rate codes for both groups
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chop_q <= `CHOP_RST;
        end else if (wrStrobe && hitChop) begin
            chop_q <= pwdata[7:0];
        end
    end

    // Read data captured in the setup cycle, so it stands through the access phase
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (clkEn && psel && !penable && !pwrite) begin
            if (hitRx) begin
                prdata <= {24'h000000, diagRx_q};
            end else if (hitSel) begin
                prdata <= {24'h000000, diagSel_q};
            end else if (hitDel) begin
                prdata <= {24'h000000, modDelay_q};
            end else if (hitChop) begin
                prdata <= {24'h000000, chop_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    assign group_a_diag_voltage = diagSel_q[`GROUP_A_DIAG_VOLTAGE_LSB +: 3];
    assign group_b_diag_voltage = diagSel_q[`GROUP_B_DIAG_VOLTAGE_LSB +: 3];
    assign delayed_modclk_select = modDelay_q[`DELSEL_LSB +: 2];
    assign group_a_chop_rate = chop_rate_t'(chop_q[`CHOPA_LSB +: 2]);
    assign group_b_chop_rate = chop_rate_t'(chop_q[`CHOPB_LSB +: 2]);

    // Undefined codes fall to off
    function automatic diag_level_t decodeLevel(input logic [2:0] code);
        case (code)
            3'h3: decodeLevel = DIAG_POS_FS;
            3'h4: decodeLevel = DIAG_NEG_FS;
            3'h5: decodeLevel = DIAG_ZERO;
            default: decodeLevel = DIAG_OFF;
        endcase
    endfunction : decodeLevel

    // Per-channel routing of level and delayed clock
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : gChan
        logic [2:0] grpCode;
        // Buffer must be on for the level to reach the input
        logic takes;
        assign grpCode = chanModeB[ch] ? group_b_diag_voltage : group_a_diag_voltage;
        assign takes = diagRx_q[ch] & prechargeBufOn[ch];
        assign chanDiagLevel[ch] = takes ? decodeLevel(grpCode) : DIAG_OFF;
        assign delayedModclkUse[ch] = (ch < 4) ? delayed_modclk_select[0]
                                               : delayed_modclk_select[1];
    end

    AST_RX_RESET: assert property (@(posedge ref_clk) srst |=> diagRx_q == 8'h00)
        else $error("receive register not cleared by reset");
    AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        wrStrobe && hitSel |=> diagSel_q == $past(pwdata[7:0]))
        else $error("selection register did not take write");
    AST_GROUPB_ROUTE: assert property (@(posedge ref_clk) disable iff (srst)
        diagRx_q[0] && prechargeBufOn[0] && chanModeB[0] && group_b_diag_voltage == 3'h4
        |-> chanDiagLevel[0] == DIAG_NEG_FS)
        else $error("group B level not routed to channel 0");
    AST_UNDEF_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        !chanModeB[7] && (group_a_diag_voltage inside {3'h1, 3'h2, 3'h6, 3'h7})
        |-> chanDiagLevel[7] == DIAG_OFF)
        else $error("undefined code not treated as off");
    AST_ZERO_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        diagRx_q[2] && prechargeBufOn[2] && !chanModeB[2] && group_a_diag_voltage == 3'h5
        |-> chanDiagLevel[2] == DIAG_ZERO)
        else $error("zero-scale code not decoded");
    AST_DELAY_RESET: assert property (@(posedge ref_clk) srst |=> modDelay_q == 8'h02 && delayedModclkUse == 8'h00)
        else $error("delay register reset wrong");
    AST_DELAY_MAP: assert property (@(posedge ref_clk) disable iff (srst)
        delayed_modclk_select == 2'h2 |-> delayedModclkUse == 8'hF0)
        else $error("delayed clock map wrong for upper channels");
    AST_CHOP_RESET: assert property (@(posedge ref_clk) srst ##1 !srst[*2] |-> chop_q == 8'h0A
        || $past(wrStrobe && hitChop))
        else $error("chop register reset value wrong");
    AST_BUF_GATE: assert property (@(posedge ref_clk) disable iff (srst)
        !prechargeBufOn[5] |-> chanDiagLevel[5] == DIAG_OFF)
        else $error("level reached a channel with buffer off");

    // Field and register write checks, and the selection register reset check
    AST_RX_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        wrStrobe && hitRx |=> diagRx_q == $past(pwdata[7:0]))
        else $error("receive register did not take write");
    AST_GROUPB_FIELD: assert property (@(posedge ref_clk) disable iff (srst)
        wrStrobe && hitSel |=> group_b_diag_voltage == $past(pwdata[6:4]))
        else $error("group B field not taken from bits 6 to 4");
    AST_CHOP_FIELD: assert property (@(posedge ref_clk) disable iff (srst)
        wrStrobe && hitChop |=> group_a_chop_rate == $past(pwdata[3:2])
        && group_b_chop_rate == $past(pwdata[1:0]))
        else $error("chop rate fields misplaced");
    AST_SEL_RESET: assert property (@(posedge ref_clk) srst |=> diagSel_q == 8'h00)
        else $error("selection register not cleared by reset");

    // Routing and decode checks
    AST_RX_GATE: assert property (@(posedge ref_clk) disable iff (srst)
        !diagRx_q[4] |-> chanDiagLevel[4] == DIAG_OFF)
        else $error("level reached a channel not taking the diagnostic");
    AST_POS_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        diagRx_q[1] && prechargeBufOn[1] && !chanModeB[1] && group_a_diag_voltage == 3'h3
        |-> chanDiagLevel[1] == DIAG_POS_FS)
        else $error("positive full-scale code not decoded");
    AST_DELAY_LOW: assert property (@(posedge ref_clk) disable iff (srst)
        delayed_modclk_select == 2'h1 |-> delayedModclkUse == 8'h0F)
        else $error("delayed clock map wrong for lower channels");
    AST_DELAY_ALL: assert property (@(posedge ref_clk) disable iff (srst)
        delayed_modclk_select == 2'h3 |-> delayedModclkUse == 8'hFF)
        else $error("delayed clock map wrong for all channels");

    // Bus side checks
    AST_READ_CHOP: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && psel && !penable && !pwrite && hitChop
        |=> prdata == {24'h000000, $past(chop_q)})
        else $error("chop register read data wrong");
    AST_READ_SEL: assert property (@(posedge ref_clk) disable iff (srst)
        clkEn && psel && !penable && !pwrite && hitSel
        |=> prdata == {24'h000000, $past(diagSel_q)})
        else $error("selection register read data wrong");
    AST_UNMAPPED_KEEP: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && pwrite && !mapped |=> $stable(diagRx_q) && $stable(diagSel_q)
        && $stable(modDelay_q) && $stable(chop_q))
        else $error("write to unmapped address changed a register");
endmodule : adc_diag_mod_chop_regs

/* File: logic/diag_chop_defines.svh */
// Offsets, field positions and reset values of the diagnostic and chop register bank.
// Included by the register bank module and the testbench.
`ifndef DIAG_CHOP_DEFINES_SVH
`define DIAG_CHOP_DEFINES_SVH
`define DIAG_RX_IDX 8'h56
`define DIAG_SEL_IDX 8'h57
`define MOD_DELAY_IDX 8'h58
`define CHOP_IDX 8'h59
`define DIAG_RX_RST 8'h00
`define DIAG_SEL_RST 8'h00
`define MOD_DELAY_RST 8'h02
`define CHOP_RST 8'h0A
`define GROUP_A_DIAG_VOLTAGE_LSB 0
`define GROUP_B_DIAG_VOLTAGE_LSB 4
`define DELSEL_LSB 2
`define CHOPA_LSB 2
`define CHOPB_LSB 0
`endif

/* File: logic/diag_chop_pkg.sv */
// Types shared by the diagnostic and chop register bank.
// Assumes nothing of its surroundings.
package diag_chop_pkg;
    typedef enum logic [2:0] {
        DIAG_OFF = 3'h0,
        DIAG_POS_FS = 3'h3,
        DIAG_NEG_FS = 3'h4,
        DIAG_ZERO = 3'h5
    } diag_level_t;
    typedef enum logic [1:0] {
        CHOP_NONE = 2'h0,
        CHOP_DIV8 = 2'h1,
        CHOP_DIV32 = 2'h2,
        CHOP_BAD = 2'h3
    } chop_rate_t;
endpackage : diag_chop_pkg

/* File: testbench/tb_top.sv */
// Self-checking bench for the diagnostic, modulator delay and chop register bank.
// Assumes the bank answers APB with zero wait states; the bench is the only master.
`timescale 1ns/1ns
`include "diag_chop_defines.svh"
module tb_top;
    import diag_chop_pkg::*;
    logic refClk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err;
    logic [7:0] modeB = 8'hF0, bufOn = 8'hFF, delUse;
    diag_level_t lvl [8];
    chop_rate_t chopA, chopB;
    int n_fail = 0, n_tests = 0, cyc = 0;
    always #20 refClk = ~refClk;
    adc_diag_mod_chop_regs u_dut (.ref_clk(refClk), .srst(srst), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chanModeB(modeB), .prechargeBufOn(bufOn),
        .chanDiagLevel(lvl), .delayedModclkUse(delUse), .group_a_chop_rate(chopA),
        .group_b_chop_rate(chopB));
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    always @(posedge refClk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge refClk);
        penable <= 1'b1;
        do begin
            @(posedge refClk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge refClk);
    endtask : apb
    task automatic regRw(input logic [7:0] idx, input logic [31:0] wd, input logic [31:0] exp);
        apb(1'b1, idx, wd);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : regRw
    task automatic testReset();
        apb(1'b0, `DIAG_RX_IDX, 32'h0);
        chk(rd, {24'h0, `DIAG_RX_RST});
        apb(1'b0, `DIAG_SEL_IDX, 32'h0);
        chk(rd, {24'h0, `DIAG_SEL_RST});
        apb(1'b0, `MOD_DELAY_IDX, 32'h0);
        chk(rd, {24'h0, `MOD_DELAY_RST});
        apb(1'b0, `CHOP_IDX, 32'h0);
        chk(rd, {24'h0, `CHOP_RST});
        chk({16'h0, delUse, 4'h0, chopA, chopB}, 32'h0000_000A);
        for (int i = 0; i < 8; i++) begin
            chk({29'h0, lvl[i]}, 32'h0);
        end
        apb(1'b0, 8'h5A, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h55, 32'hFF);
        chk({31'h0, err}, 32'h1);
    endtask : testReset
    task automatic testDiag();
        logic [2:0] code, e;
        regRw(`DIAG_RX_IDX, 32'hFFFF_FFFF, 32'hFF);
        for (int c = 0; c < 8; c++) begin
            regRw(`DIAG_SEL_IDX, {25'h0, 3'(7 - c), 1'b0, 3'(c)}, {25'h0, 3'(7 - c), 1'b0, 3'(c)});
            for (int i = 0; i < 8; i++) begin
                code = modeB[i] ? 3'(7 - c) : 3'(c);
                e = (code == 3'h3 || code == 3'h4 || code == 3'h5) ? code : 3'h0;
                if (!bufOn[i]) e = 3'h0;
                chk({29'h0, lvl[i]}, {29'h0, e});
            end
        end
        regRw(`DIAG_SEL_IDX, 32'h33, 32'h33);
        bufOn <= 8'hDF;
        @(posedge refClk);
        chk({29'h0, lvl[5]}, 32'h0);
        chk({29'h0, lvl[4]}, 32'h3);
        bufOn <= 8'hFF;
        regRw(`DIAG_RX_IDX, 32'hBF, 32'hBF);
        chk({29'h0, lvl[6]}, 32'h0);
        chk({29'h0, lvl[7]}, 32'h3);
        regRw(`DIAG_SEL_IDX, 32'h0, 32'h0);
    endtask : testDiag
    task automatic testDelay();
        for (int d = 0; d < 4; d++) begin
            regRw(`MOD_DELAY_IDX, {28'h0, 2'(d), 2'b10}, {28'h0, 2'(d), 2'b10});
            chk({24'h0, delUse}, {24'h0, {4{d[1]}}, {4{d[0]}}});
        end
    endtask : testDelay
    task automatic testChop();
        for (int c = 0; c < 16; c++) begin
            regRw(`CHOP_IDX, {28'hFFFFFFF, 4'(c)}, {24'h0, 4'hF, 4'(c)});
            chk({28'h0, chopA, chopB}, {28'h0, 4'(c)});
        end
    endtask : testChop
    initial begin
        repeat (16) @(posedge refClk);
        srst <= 1'b0;
        @(posedge refClk);
        testReset();
        testDiag();
        modeB <= 8'h0F;
        bufOn <= 8'hFF;
        testDiag();
        testDelay();
        testChop();
        results();
    end
endmodule : tb_top
